/* src/pkg_config_pkg.sv */
// constants and types for the package configuration read block
package pkg_config_pkg;

  // ==========================================================
  // service selection
  localparam logic [7:0] IDX_PKG_IDENT = 8'h00;
  localparam logic [7:0] IDX_SKU_UNIT = 8'h1e;
  localparam logic [7:0] IDX_SKU_POWER = 8'h1c;

  localparam logic [15:0] PRM_SIGNATURE = 16'h0000;
  localparam logic [15:0] PRM_PLATFORM = 16'h0001;
  localparam logic [15:0] PRM_DEVICE_ID = 16'h0002;
  localparam logic [15:0] PRM_MAX_THREAD = 16'h0003;
  localparam logic [15:0] PRM_MICROCODE = 16'h0004;
  localparam logic [15:0] PRM_MC_STATUS = 16'h0005;
  localparam logic [15:0] PRM_SKU_LOW = 16'h0000;
  localparam logic [15:0] PRM_SKU_HIGH = 16'h0001;

  // ==========================================================
  // completion codes
  localparam logic [7:0] CC_OK = 8'h40;
  localparam logic [7:0] CC_BAD_PARAM = 8'h90;

  // ==========================================================
  // processor signature layout
  localparam int SIG_STEP_LSB = 0;
  localparam int SIG_MODEL_LSB = 4;
  localparam int SIG_FAMILY_LSB = 8;
  localparam int SIG_TYPE_LSB = 12;
  localparam int SIG_EXT_MODEL_LSB = 16;
  localparam int SIG_EXT_FAMILY_LSB = 20;
  localparam int PLATFORM_FLAG_W = 3;

  // ==========================================================
  // error source log bits
  localparam int ERR_MCE_BIT = 29;
  localparam int ERR_INT_BIT = 30;
  localparam int ERR_CAT_BIT = 31;
  localparam int NUM_ERR = 3;

  // ==========================================================
  // unit word layout and defaults
  localparam int UNIT_POWER_LSB = 0;
  localparam int UNIT_ENERGY_LSB = 8;
  localparam int UNIT_TIME_LSB = 16;
  localparam logic [3:0] UNIT_POWER_RST = 4'h3;
  localparam logic [4:0] UNIT_ENERGY_RST = 5'h10;
  localparam logic [3:0] UNIT_TIME_RST = 4'ha;

  // ==========================================================
  // power limit word layout
  localparam int SKU_TDP_LSB = 0;
  localparam int SKU_MIN_LSB = 16;
  localparam int SKU_MAX_LSB = 32;
  localparam int SKU_WIN_LSB = 48;
  localparam int SKU_PWR_W = 15;
  localparam int SKU_WIN_W = 7;

  // arbitrary neutral value, not tied to any real part
  localparam logic [31:0] POWER_CTRL_DEVICE_ID = 32'h0000_0a5c;

  // ==========================================================
  // carried groups
  typedef struct packed {
    logic [7:0] index;
    logic [15:0] param;
  } cfg_req_t;

  typedef struct packed {
    logic [7:0] cc;
    logic [31:0] data;
  } cfg_rsp_t;

  typedef struct packed {
    logic [3:0] stepping;
    logic [3:0] model;
    logic [3:0] family;
    logic [1:0] proc_type;
    logic [3:0] ext_model;
    logic [7:0] ext_family;
  } signature_t;

  typedef struct packed {
    logic [SKU_WIN_W-1:0] max_window;
    logic [SKU_PWR_W-1:0] max_power;
    logic [SKU_PWR_W-1:0] min_power;
    logic [SKU_PWR_W-1:0] tdp_power;
  } sku_limits_t;

endpackage

/* src/pkg_config_reads.sv */
// package identity, error log, unit and power limit read services
//
// Operation
// - identification read selected by parameter value
// - signature word field layout, upper bits zero
// - platform flags in bits two to zero
// - power-control device id fixed for all variants
// - max thread id from variant, not enables
// - single 32-bit microcode and firmware revision
// - error log bits 29, 30, 31
// - error bit set when condition occurs
// - catastrophic bit may flag other errors
// - unit word fields with reset defaults
// - power limit word read as two halves
// - tdp power in bits 14..0
// - maximum power in bits 46..32
// - minimum power in bits 30..16
// - maximum time window in bits 54..48
// - limit word loaded by firmware at boot
`timescale 1ns/1ps
`default_nettype none

module pkg_config_reads (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // read request from the sideband management link decoder
  input wire logic rd_req_i,
  input wire pkg_config_pkg::cfg_req_t rd_cmd_i,
  // read answer
  output logic rsp_valid_o,
  output pkg_config_pkg::cfg_rsp_t rsp_o,
  // identity straps, caught once after reset
  input wire pkg_config_pkg::signature_t signature_i,
  input wire logic [2:0] platform_flags_i,
  input wire logic [7:0] max_thread_id_i,
  input wire logic [31:0] microcode_rev_i,
  // error pins from outside the clock domain
  input wire logic machine_check_error_i,
  input wire logic internal_error_i,
  input wire logic catastrophic_error_pin_n_i,
  input wire logic cat_flags_other_errors_i,
  // power control firmware boot load
  input wire logic sku_load_i,
  input wire pkg_config_pkg::sku_limits_t sku_load_data_i,
  // state seen by the rest of the device
  output logic [31:0] error_log_o
);
  import pkg_config_pkg::*;

  // ==========================================================
  // identity capture
  logic captured_reg;
  logic [31:0] signature_reg;
  logic [31:0] platform_reg;
  logic [31:0] max_thread_reg;
  logic [31:0] microcode_reg;

  // straps are sampled by the clock after release, never by the reset itself
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      captured_reg <= 1'b0;
      signature_reg <= 32'h0000_0000;
      platform_reg <= 32'h0000_0000;
      max_thread_reg <= 32'h0000_0000;
      microcode_reg <= 32'h0000_0000;
    end else if (!captured_reg) begin
      captured_reg <= 1'b1;
      signature_reg <= {4'h0, signature_i.ext_family, signature_i.ext_model, 2'b00,
                        signature_i.proc_type, signature_i.family, signature_i.model,
                        signature_i.stepping};
      platform_reg <= {29'h0000_0000, platform_flags_i};
      max_thread_reg <= {24'h00_0000, max_thread_id_i};
      microcode_reg <= microcode_rev_i;
    end
  end

  // ==========================================================
  // error pin synchronisers
  logic [NUM_ERR-1:0] err_raw;
  logic [NUM_ERR-1:0] err_level;
  assign err_raw = {~catastrophic_error_pin_n_i, internal_error_i, machine_check_error_i};

  genvar g;
  generate
    for (g = 0; g < NUM_ERR; g++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          lvl_reg <= 1'b0;
        end else begin
          s1_reg <= err_raw[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // a change counts only once two stages agree, filtering one-cycle glitches
          if (s2_reg == s3_reg) begin
            lvl_reg <= s3_reg;
          end
        end
      end
      assign err_level[g] = lvl_reg;
    end
  endgenerate

  // ==========================================================
  // error source log
  logic [NUM_ERR-1:0] err_prev_reg;
  logic [NUM_ERR-1:0] err_rise;
  logic [31:0] error_log_reg;
  assign err_rise = err_level & ~err_prev_reg;

  // the log is sticky until reset; no read clears it
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      err_prev_reg <= '0;
      error_log_reg <= 32'h0000_0000;
    end else begin
      err_prev_reg <= err_level;
      if (err_rise[0]) begin
        error_log_reg[ERR_MCE_BIT] <= 1'b1;
      end
      if (err_rise[1]) begin
        error_log_reg[ERR_INT_BIT] <= 1'b1;
      end
      if (err_rise[2] || (cat_flags_other_errors_i && (err_rise[0] || err_rise[1]))) begin
        error_log_reg[ERR_CAT_BIT] <= 1'b1;
      end
    end
  end
  assign error_log_o = error_log_reg;

  // ==========================================================
  // unit word and power limit word
  logic [31:0] unit_reg;
  logic [63:0] sku_reg;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      unit_reg <= 32'h0000_0000;
      unit_reg[UNIT_POWER_LSB +: 4] <= UNIT_POWER_RST;
      unit_reg[UNIT_ENERGY_LSB +: 5] <= UNIT_ENERGY_RST;
      unit_reg[UNIT_TIME_LSB +: 4] <= UNIT_TIME_RST;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sku_reg <= 64'h0000_0000_0000_0000;
    end else if (sku_load_i) begin
      sku_reg <= 64'h0000_0000_0000_0000;
      sku_reg[SKU_TDP_LSB +: SKU_PWR_W] <= sku_load_data_i.tdp_power;
      sku_reg[SKU_MIN_LSB +: SKU_PWR_W] <= sku_load_data_i.min_power;
      sku_reg[SKU_MAX_LSB +: SKU_PWR_W] <= sku_load_data_i.max_power;
      sku_reg[SKU_WIN_LSB +: SKU_WIN_W] <= sku_load_data_i.max_window;
    end
  end

  // ==========================================================
  // read decode
  cfg_rsp_t rsp_next;

  always_comb begin
    rsp_next.cc = CC_BAD_PARAM;
    rsp_next.data = 32'h0000_0000;
    unique case (rd_cmd_i.index)
      IDX_PKG_IDENT: begin
        rsp_next.cc = CC_OK;
        unique case (rd_cmd_i.param)
          PRM_SIGNATURE: rsp_next.data = signature_reg;
          PRM_PLATFORM: rsp_next.data = platform_reg;
          PRM_DEVICE_ID: rsp_next.data = POWER_CTRL_DEVICE_ID;
          PRM_MAX_THREAD: rsp_next.data = max_thread_reg;
          PRM_MICROCODE: rsp_next.data = microcode_reg;
          PRM_MC_STATUS: rsp_next.data = error_log_reg;
          default: rsp_next.cc = CC_BAD_PARAM;
        endcase
      end
      IDX_SKU_UNIT: begin
        rsp_next.cc = CC_OK;
        rsp_next.data = unit_reg;
      end
      IDX_SKU_POWER: begin
        rsp_next.cc = CC_OK;
        unique case (rd_cmd_i.param)
          PRM_SKU_LOW: rsp_next.data = sku_reg[31:0];
          PRM_SKU_HIGH: rsp_next.data = sku_reg[63:32];
          default: rsp_next.cc = CC_BAD_PARAM;
        endcase
      end
      default: begin
        rsp_next.cc = CC_BAD_PARAM;
      end
    endcase
  end

  // answer one cycle after the request, held until the next one
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rsp_valid_o <= 1'b0;
      rsp_o <= '0;
    end else begin
      rsp_valid_o <= rd_req_i;
      if (rd_req_i) begin
        rsp_o <= rsp_next;
      end
    end
  end

endmodule

`default_nettype wire

/* test/pkg_config_monitor.sv */
// checker for the package config read block
`timescale 1ns/1ps
`default_nettype none
// ====================
// read answer and error log checks
module pkg_config_monitor
  import pkg_config_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic rd_req_i,
  input wire pkg_config_pkg::cfg_req_t rd_cmd_i,
  input wire logic internal_error_i,
  input wire logic rsp_valid_o,
  input wire pkg_config_pkg::cfg_rsp_t rsp_o,
  input wire logic [31:0] error_log_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic [7:0] ix;
  logic [15:0] pr;
  assign ix = rd_cmd_i.index;
  assign pr = rd_cmd_i.param;
  answer_follows_a: assert property (rd_req_i |=> rsp_valid_o)
    else $error("no answer one cycle after a request");
  no_spurious_a: assert property (!rd_req_i |=> !rsp_valid_o)
    else $error("answer without a request");
  rsp_holds_a: assert property (!rsp_valid_o |-> $stable(rsp_o))
    else $error("answer changed between answers");
  devid_fixed_a: assert property (rd_req_i && ix == IDX_PKG_IDENT
    && pr == PRM_DEVICE_ID |=> rsp_o == {CC_OK, POWER_CTRL_DEVICE_ID})
    else $error("device id answer wrong");
  unit_word_a: assert property (rd_req_i && ix == IDX_SKU_UNIT
    && pr == 16'h0000 |=> rsp_o == {CC_OK, 32'h000a_1003})
    else $error("unit word wrong");
  sku_reserved_a: assert property (rd_req_i && ix == IDX_SKU_POWER
    |=> !rsp_o.data[31] && !rsp_o.data[15])
    else $error("limit word reserved bit set");
  bad_index_a: assert property (rd_req_i && !(ix inside {8'h00, 8'h1e, 8'h1c})
    |=> rsp_o == {CC_BAD_PARAM, 32'h0})
    else $error("unknown index not refused");
  log_reserved_a: assert property (error_log_o[28:0] == 29'h0)
    else $error("error log reserved bits set");
  log_sticky_a: assert property ((error_log_o & $past(error_log_o))
    == $past(error_log_o))
    else $error("error log bit cleared");
  internal_error_logged_a: assert property ($rose(internal_error_i)
    |-> ##[4:6] error_log_o[30])
    else $error("internal error not logged in time");
  cover property (rd_req_i && ix == IDX_SKU_POWER);
  cover property ($rose(error_log_o[31]));
  cover property (rd_req_i && ix == IDX_PKG_IDENT && pr == PRM_MC_STATUS);
endmodule
bind pkg_config_reads pkg_config_monitor mon (.mclk_i(mclk_i), .reset_i(reset_i),
  .rd_req_i(rd_req_i), .rd_cmd_i(rd_cmd_i), .internal_error_i(internal_error_i),
  .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .error_log_o(error_log_o));
`default_nettype wire

/* test/host_model.sv */
// host side model issuing package config reads
`timescale 1ns/1ps
`default_nettype none
// ====================
// read requester
module host_model
  import pkg_config_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rsp_valid_i,
  input wire pkg_config_pkg::cfg_rsp_t rsp_i,
  output logic rd_req_o,
  output pkg_config_pkg::cfg_req_t rd_cmd_o
);
  initial begin
    rd_req_o = 1'b0;
    rd_cmd_o = '0;
  end
  // the minimum time window lives in another register, never asked for here
  // each half is its own request
  task automatic read(input logic [7:0] ix, input logic [15:0] pr,
                      output cfg_rsp_t r, output bit ok);
    ok = 1'b0;
    r = '0;
    @(negedge mclk_i);
    rd_req_o = 1'b1;
    rd_cmd_o = {ix, pr};
    @(negedge mclk_i);
    rd_req_o = 1'b0;
    // released lines must not keep the last command
    rd_cmd_o = ~rd_cmd_o;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rsp_valid_i === 1'b1) begin
        ok = 1'b1;
        r = rsp_i;
      end else begin
        @(negedge mclk_i);
      end
    end
  endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the package config read block
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench top
module tb_top;
  import pkg_config_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic rd_req, rsp_valid, sku_ld = 0;
  logic mce = 0, internal_error = 0, cat_n = 1, cat_oth = 0;
  cfg_req_t rd_cmd;
  cfg_rsp_t rsp;
  signature_t sig = '{4'h7, 4'h5, 4'h6, 2'h2, 4'h3, 8'h01};
  // boot limits keep min below tdp below max
  sku_limits_t sku = '{7'h45, 15'h5abc, 15'h1234, 15'h2e01};
  logic [31:0] log_o;
  int num_errors = 0;
  int total_checks = 0;
  initial forever #12.5 mclk_i = ~mclk_i;
  pkg_config_reads DUT (.mclk_i(mclk_i), .reset_i(reset_i), .rd_req_i(rd_req),
    .rd_cmd_i(rd_cmd), .rsp_valid_o(rsp_valid), .rsp_o(rsp), .signature_i(sig),
    .platform_flags_i(3'h5), .max_thread_id_i(8'h0b), .microcode_rev_i(32'h1234_5678),
    .machine_check_error_i(mce), .internal_error_i(internal_error),
    .catastrophic_error_pin_n_i(cat_n), .cat_flags_other_errors_i(cat_oth),
    .sku_load_i(sku_ld), .sku_load_data_i(sku), .error_log_o(log_o));
  host_model host (.mclk_i(mclk_i), .rsp_valid_i(rsp_valid), .rsp_i(rsp),
    .rd_req_o(rd_req), .rd_cmd_o(rd_cmd));
  task automatic end_of_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_cc(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t cc got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t data got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] ix, input logic [15:0] pr,
                    input logic [7:0] cc, input logic [31:0] d);
    cfg_rsp_t r;
    bit ok;
    host.read(ix, pr, r, ok);
    if (!ok) begin
      num_errors++;
      end_of_test();
    end
    chk_cc(r.cc, cc);
    chk_data(r.data, d);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic do_reset();
    reset_i = 1'b1;
    wait_cyc(6);
    reset_i = 1'b0;
    wait_cyc(2);
  endtask
  task automatic t_ident();
    rd(IDX_PKG_IDENT, PRM_SIGNATURE, CC_OK, {4'h0, sig.ext_family, sig.ext_model,
       2'b0, sig.proc_type, sig.family, sig.model, sig.stepping});
    rd(IDX_PKG_IDENT, PRM_PLATFORM, CC_OK, 32'h5);
    rd(IDX_PKG_IDENT, PRM_DEVICE_ID, CC_OK, POWER_CTRL_DEVICE_ID);
    rd(IDX_PKG_IDENT, PRM_MAX_THREAD, CC_OK, 32'h0b);
    rd(IDX_PKG_IDENT, PRM_MICROCODE, CC_OK, 32'h1234_5678);
    rd(IDX_PKG_IDENT, 16'h0006, CC_BAD_PARAM, 32'h0);
  endtask
  task automatic t_unit();
    cfg_rsp_t r;
    bit ok;
    rd(IDX_SKU_UNIT, 16'h0, CC_OK, {12'h0, UNIT_TIME_RST, 3'h0,
       UNIT_ENERGY_RST, 4'h0, UNIT_POWER_RST});
    host.read(IDX_SKU_UNIT, 16'h0, r, ok);
    // host scaling of the reported units, in mW and us per count
    chk_data(32'd1000 >> r.data[3:0], 32'd125);
    chk_data(32'd1_000_000 >> r.data[19:16], 32'd976);
    rd(8'h77, 16'h0, CC_BAD_PARAM, 32'h0);
  endtask
  task automatic t_sku();
    rd(IDX_SKU_POWER, PRM_SKU_LOW, CC_OK, 32'h0);
    sku_ld = 1'b1;
    wait_cyc(1);
    sku_ld = 1'b0;
    rd(IDX_SKU_POWER, PRM_SKU_LOW, CC_OK, {1'b0, sku.min_power, 1'b0, sku.tdp_power});
    rd(IDX_SKU_POWER, PRM_SKU_HIGH, CC_OK, {9'h0, sku.max_window, 1'b0, sku.max_power});
    rd(IDX_SKU_POWER, 16'h0002, CC_BAD_PARAM, 32'h0);
  endtask
  task automatic t_err();
    mce = 1'b1;
    wait_cyc(10);
    rd(IDX_PKG_IDENT, PRM_MC_STATUS, CC_OK, 32'h2000_0000);
    cat_oth = 1'b1;
    internal_error = 1'b1;
    wait_cyc(10);
    rd(IDX_PKG_IDENT, PRM_MC_STATUS, CC_OK, 32'he000_0000);
    mce = 1'b0;
    internal_error = 1'b0;
    cat_oth = 1'b0;
    wait_cyc(10);
    chk_data(log_o, 32'he000_0000);
    do_reset();
    chk_data(log_o, 32'h0);
    cat_n = 1'b0;
    wait_cyc(10);
    rd(IDX_PKG_IDENT, PRM_MC_STATUS, CC_OK, 32'h8000_0000);
    cat_n = 1'b1;
  endtask
  initial begin
    do_reset();
    t_ident();
    t_unit();
    t_sku();
    t_err();
    end_of_test();
  end
endmodule
`default_nettype wire
